// >>> logic/fast_timer_pkg.sv
// Constants, register map and carrier types of the fast timer count/compare block
package fast_timer_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int unsigned CLK_HZ          = 25_000_000;  // Core clock rate
   localparam int unsigned PLL_SETTLE_US   = 100;         // PLL steady within this time
   // Longest time, so rounded down to whole cycles
   localparam int unsigned PLL_SETTLE_CYC  = (PLL_SETTLE_US * CLK_HZ) / 1_000_000;
   localparam logic [1:0]  SYNC_WR_DELAY   = 2'h2;        // One and a half cycles, rounded up
   localparam logic [1:0]  ASYNC_WR_DELAY  = 2'h1;        // At most one cycle
   localparam int unsigned FLAG_SYNC_STAGES = 2;          // Match-to-flag delay stages

   // ==========================================================================
   // Register offsets on the 8-bit I/O bus
   // ==========================================================================
   localparam logic [5:0] ADDR_HIGH_TEMP  = 6'h25;
   localparam logic [5:0] ADDR_PLL_STATUS = 6'h29;
   localparam logic [5:0] ADDR_CMP_D      = 6'h2a;
   localparam logic [5:0] ADDR_TOP        = 6'h2b;
   localparam logic [5:0] ADDR_CMP_B      = 6'h2c;
   localparam logic [5:0] ADDR_CMP_A      = 6'h2d;
   localparam logic [5:0] ADDR_COUNT_LOW  = 6'h2e;
   localparam logic [5:0] ADDR_IRQ_FLAGS  = 6'h38;
   localparam logic [5:0] ADDR_IRQ_MASK   = 6'h39;

   // ==========================================================================
   // Field positions in flag and mask bytes
   // ==========================================================================
   localparam int unsigned BIT_CMP_D = 7;
   localparam int unsigned BIT_CMP_A = 6;
   localparam int unsigned BIT_CMP_B = 5;
   localparam int unsigned BIT_OVF   = 2;
   localparam int unsigned BIT_LOCK  = 0;

   // Channel index in the four-bit event vectors
   localparam int unsigned CH_B   = 0;
   localparam int unsigned CH_A   = 1;
   localparam int unsigned CH_D   = 2;
   localparam int unsigned CH_OVF = 3;

   // ==========================================================================
   // Reset values and limits
   // ==========================================================================
   localparam logic [9:0] COUNT_RST = 10'h000;
   localparam logic [9:0] CMP_RST   = 10'h000;
   localparam logic [9:0] TOP_RST   = 10'h3ff;
   localparam logic [9:0] TOP_MIN   = 10'h003;
   localparam logic [1:0] TEMP_RST  = 2'h0;
   localparam logic [3:0] MASK_RST  = 4'h0;

   // ==========================================================================
   // Types
   // ==========================================================================
   // Counting direction, one-hot
   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } dir_t;

   // One I/O bus request from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } io_req_t;

   // Mode selection from the neighbouring control logic
   typedef struct packed {
      logic async_clk;   // Counter runs from the fast peripheral clock
      logic pwm;         // Any PWM mode
      logic dual_slope;  // Phase and frequency correct counting
   } timer_mode_t;

endpackage : fast_timer_pkg

// >>> logic/event_sync_delay.sv
// Fixed-length delay line that carries one-cycle events toward their flags
`timescale 1ns/100ps
`default_nettype none

module event_sync_delay
#(
   parameter int unsigned WIDTH  = 4,
   parameter int unsigned STAGES = 2
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Events in and out
   input  wire logic [WIDTH-1:0] evt_i,
   output logic      [WIDTH-1:0] evt_o
);

   // ==========================================================================
   // Stage registers
   // ==========================================================================
   logic [WIDTH-1:0] stage_q [STAGES];  // Delay stages, index 0 first

   genvar s;
   generate
      for (s = 0; s < STAGES; s++)
      begin : g_stage
         // Each stage takes the one before it
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               stage_q[s] <= '0;
            else if (s == 0)
               stage_q[s] <= evt_i;
            else
               stage_q[s] <= stage_q[(s == 0) ? 0 : s - 1];
         end
      end
   endgenerate

   assign evt_o = stage_q[STAGES-1];

endmodule // event_sync_delay

`default_nettype wire

// >>> logic/fast_timer_count_compare_regs.sv
// Counter, compare, flag and mask registers of the 10-bit fast timer
//
// Contract
// - Lock flag high only while PLL locked
// - PLL settles within 100 us of start
// - Counter is 10-bit up/down, read and write
// - Counter write delayed 1.5 or 1 cycles
// - Counter counts up after any write
// - Works as 8-bit counter with high zero
// - High temp holds bits 9:8, rest zero
// - One high temp shared by all registers
// - Match only when counting into compare value
// - Match sets flag after synchronization delay
// - Top match clears counter, except in dual-slope where it turns around
// - Top writes below three store three
// - Compares 10-bit, high bits through temp
// - Mask bits 7,6,5,2, reset zero
// - Overflow at top, or bottom in dual-slope
// - Flags cleared by vector or write-one
// - Interrupt needs flag, enable and global enable
`timescale 1ns/100ps
`default_nettype none

module fast_timer_count_compare_regs
(
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rstn_i,
   // I/O bus
   input  wire fast_timer_pkg::io_req_t      io_req_i,
   output logic                      [7:0]   io_rdata_o,
   // Timer control
   input  wire fast_timer_pkg::timer_mode_t  mode_i,
   input  wire logic                         count_tick_i,
   input  wire logic                         global_ie_i,
   input  wire logic                 [3:0]   irq_ack_i,
   // PLL status
   input  wire logic                         pll_enable_i,
   input  wire logic                         pll_locked_i,
   output logic                              pll_lock_flag_o,
   output logic                              pll_settled_o,
   // Timer results
   output logic                      [9:0]   count_o,
   output logic                      [3:0]   cmp_match_o,
   output logic                      [3:0]   irq_o
);

   // ==========================================================================
   // Reset release
   // ==========================================================================
   logic rst_meta_q;  // First stage, read only by the second
   logic rstn;        // Released reset used everywhere else

   // Assert at once, release two edges later
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_q <= 1'b0;
         rstn       <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rstn       <= rst_meta_q;
      end
   end

   // ==========================================================================
   // PLL lock synchroniser and settle timer
   // ==========================================================================
   logic        lock_meta_q;    // First stage of the lock pin
   logic        lock_sync_q;    // Usable lock level
   logic [11:0] settle_cnt_q;   // Cycles since PLL enable
   logic        settle_done;    // Settle time has passed

   localparam logic [11:0] SETTLE_LAST = 12'(fast_timer_pkg::PLL_SETTLE_CYC);

   assign settle_done = (settle_cnt_q == SETTLE_LAST);

   // Lock pin comes from the analogue PLL, so it is synchronised first
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         lock_meta_q     <= 1'b0;
         lock_sync_q     <= 1'b0;
         pll_lock_flag_o <= 1'b0;
      end
      else
      begin
         lock_meta_q     <= pll_locked_i;
         lock_sync_q     <= lock_meta_q;
         pll_lock_flag_o <= lock_sync_q;
      end
   end

   // The lock flag may chatter before this; settled marks when it is trustworthy
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         settle_cnt_q  <= '0;
         pll_settled_o <= 1'b0;
      end
      else if (!pll_enable_i)
      begin
         settle_cnt_q  <= '0;
         pll_settled_o <= 1'b0;
      end
      else
      begin
         if (!settle_done)
            settle_cnt_q <= settle_cnt_q + 12'h001;
         pll_settled_o <= settle_done;
      end
   end

   // ==========================================================================
   // Register decode
   // ==========================================================================
   logic       wr_temp, wr_count, wr_cmp_a, wr_cmp_b, wr_cmp_d, wr_top;
   logic       wr_flags, wr_mask;
   logic       rd_count, rd_cmp_a, rd_cmp_b, rd_cmp_d, rd_top;
   logic       wr, rd;     // Bus strobes
   logic [5:0] addr;       // Bus offset
   logic [3:0] clr_bits;   // Written flag and mask fields, by channel
   logic [9:0] wr_full;    // High temp joined with the written low byte
   logic [9:0] top_wval;   // Top value after the floor of three

   assign wr       = io_req_i.wr;
   assign rd       = io_req_i.rd;
   assign addr     = io_req_i.addr;
   assign wr_temp  = wr && addr == fast_timer_pkg::ADDR_HIGH_TEMP;
   assign wr_count = wr && addr == fast_timer_pkg::ADDR_COUNT_LOW;
   assign wr_cmp_a = wr && addr == fast_timer_pkg::ADDR_CMP_A;
   assign wr_cmp_b = wr && addr == fast_timer_pkg::ADDR_CMP_B;
   assign wr_cmp_d = wr && addr == fast_timer_pkg::ADDR_CMP_D;
   assign wr_top   = wr && addr == fast_timer_pkg::ADDR_TOP;
   assign wr_flags = wr && addr == fast_timer_pkg::ADDR_IRQ_FLAGS;
   assign wr_mask  = wr && addr == fast_timer_pkg::ADDR_IRQ_MASK;
   assign rd_count = rd && addr == fast_timer_pkg::ADDR_COUNT_LOW;
   assign rd_cmp_a = rd && addr == fast_timer_pkg::ADDR_CMP_A;
   assign rd_cmp_b = rd && addr == fast_timer_pkg::ADDR_CMP_B;
   assign rd_cmp_d = rd && addr == fast_timer_pkg::ADDR_CMP_D;
   assign rd_top   = rd && addr == fast_timer_pkg::ADDR_TOP;

   logic [1:0] temp_q;     // Shared high-bits temp
   assign wr_full  = {temp_q, io_req_i.wdata};
   // Below three the top would make the counter degenerate
   assign top_wval = (wr_full < fast_timer_pkg::TOP_MIN) ? fast_timer_pkg::TOP_MIN : wr_full;

   // ==========================================================================
   // Compare and top registers
   // ==========================================================================
   logic [9:0] cmp_a_q, cmp_b_q, cmp_d_q, top_q;
   logic [9:0] count_q;    // Live counter
   logic [3:0] mask_q;     // Enables, indexed by channel

   // A low-byte write loads all ten bits at once; 8-bit users keep temp at zero
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         cmp_a_q <= fast_timer_pkg::CMP_RST;
         cmp_b_q <= fast_timer_pkg::CMP_RST;
         cmp_d_q <= fast_timer_pkg::CMP_RST;
         top_q   <= fast_timer_pkg::TOP_RST;
      end
      else
      begin
         if (wr_cmp_a)
            cmp_a_q <= wr_full;
         if (wr_cmp_b)
            cmp_b_q <= wr_full;
         if (wr_cmp_d)
            cmp_d_q <= wr_full;
         if (wr_top)
            top_q   <= top_wval;
      end
   end

   // One temp for all five registers; a low read parks the high bits here
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
         temp_q <= fast_timer_pkg::TEMP_RST;
      else if (wr_temp)
         temp_q <= io_req_i.wdata[1:0];
      else if (rd_count)
         temp_q <= count_q[9:8];
      else if (rd_cmp_a)
         temp_q <= cmp_a_q[9:8];
      else if (rd_cmp_b)
         temp_q <= cmp_b_q[9:8];
      else if (rd_cmp_d)
         temp_q <= cmp_d_q[9:8];
      else if (rd_top)
         temp_q <= top_q[9:8];
   end

   // Mask holds only this timer's four enables
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
         mask_q <= fast_timer_pkg::MASK_RST;
      else if (wr_mask)
         mask_q <= clr_bits;
   end

   // ==========================================================================
   // Counter write pipeline
   // ==========================================================================
   logic       pend_q;      // A counter write is in flight
   logic [9:0] pend_val_q;  // Value waiting to land
   logic [1:0] pend_cnt_q;  // Cycles left until it lands
   logic       apply;       // Write lands this cycle

   assign apply = pend_q && (pend_cnt_q == 2'h1);

   // The delay models the core-to-counter synchronisation of each clock mode
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         pend_q     <= 1'b0;
         pend_val_q <= fast_timer_pkg::COUNT_RST;
         pend_cnt_q <= 2'h0;
      end
      else if (wr_count)
      begin
         pend_q     <= 1'b1;
         pend_val_q <= wr_full;
         pend_cnt_q <= mode_i.async_clk ? fast_timer_pkg::ASYNC_WR_DELAY
                                        : fast_timer_pkg::SYNC_WR_DELAY;
      end
      else if (pend_q)
      begin
         pend_q     <= !apply;
         pend_cnt_q <= pend_cnt_q - 2'h1;
      end
   end

   // ==========================================================================
   // Counter next state
   // ==========================================================================
   fast_timer_pkg::dir_t dir_q, dir_d;
   logic [9:0] count_d;
   logic       counted;   // Counter moved by a tick, not by software
   logic       ovf_evt;   // Overflow event this cycle
   logic       top_evt;   // Top match event this cycle
   logic       dual;      // Dual-slope counting in force
   logic       at_top;

   assign dual    = mode_i.pwm && mode_i.dual_slope;
   assign at_top  = (count_q == top_q);
   assign counted = count_tick_i && !apply;

   // Ticks come from the prescaler on this clock as one-cycle enables
   always_comb
   begin
      count_d = count_q;
      dir_d   = dir_q;
      ovf_evt = 1'b0;
      top_evt = 1'b0;
      if (apply)
      begin
         count_d = pend_val_q;
         dir_d   = fast_timer_pkg::DIR_UP;
      end
      else if (count_tick_i && !dual)
      begin
         if (at_top)
         begin
            count_d = '0;
            top_evt = 1'b1;
            ovf_evt = 1'b1;
         end
         else
            count_d = count_q + 10'h001;
      end
      else if (count_tick_i)
      begin
         unique case (dir_q)
            fast_timer_pkg::DIR_UP:
            begin
               if (at_top)
               begin
                  // Top turns the dual-slope counter around
                  count_d = count_q - 10'h001;
                  dir_d   = fast_timer_pkg::DIR_DOWN;
                  top_evt = 1'b1;
               end
               else
                  count_d = count_q + 10'h001;
            end
            fast_timer_pkg::DIR_DOWN:
            begin
               if (count_q == 10'h000)
               begin
                  count_d = 10'h001;
                  dir_d   = fast_timer_pkg::DIR_UP;
               end
               else
               begin
                  count_d = count_q - 10'h001;
                  ovf_evt = (count_q == 10'h001);
               end
            end
         endcase
      end
   end

   // Counter and direction registers
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= fast_timer_pkg::COUNT_RST;
         dir_q   <= fast_timer_pkg::DIR_UP;
      end
      else
      begin
         count_q <= count_d;
         dir_q   <= dir_d;
      end
   end

   // ==========================================================================
   // Match events and flags
   // ==========================================================================
   logic [3:0] evt;        // Raw events, indexed by channel
   logic [3:0] set_evt;    // Events after the synchronisation delay
   logic [3:0] flags_q;    // Sticky flags
   logic [3:0] clr_q;      // Write-one clears, one cycle late
   // A software write never makes a match, only a tick into the value does
   assign evt[fast_timer_pkg::CH_A]   = counted && (count_d == cmp_a_q);
   assign evt[fast_timer_pkg::CH_B]   = counted && (count_d == cmp_b_q);
   assign evt[fast_timer_pkg::CH_D]   = counted && (count_d == cmp_d_q);
   assign evt[fast_timer_pkg::CH_OVF] = ovf_evt;

   assign clr_bits[fast_timer_pkg::CH_D]   = io_req_i.wdata[fast_timer_pkg::BIT_CMP_D];
   assign clr_bits[fast_timer_pkg::CH_A]   = io_req_i.wdata[fast_timer_pkg::BIT_CMP_A];
   assign clr_bits[fast_timer_pkg::CH_B]   = io_req_i.wdata[fast_timer_pkg::BIT_CMP_B];
   assign clr_bits[fast_timer_pkg::CH_OVF] = io_req_i.wdata[fast_timer_pkg::BIT_OVF];

   // Delay from match to flag
   event_sync_delay
   #(
      .WIDTH  (4),
      .STAGES (fast_timer_pkg::FLAG_SYNC_STAGES)
   )
   u_flag_delay
   (
      .clk_i  (clk_i),
      .rstn_i (rstn),
      .evt_i  (evt),
      .evt_o  (set_evt)
   );

   // Set beats clear so an event landing on a clear is kept
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         clr_q   <= 4'h0;
         flags_q <= 4'h0;
      end
      else
      begin
         clr_q   <= wr_flags ? clr_bits : 4'h0;
         flags_q <= (flags_q & ~(clr_q | irq_ack_i)) | set_evt;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   logic [7:0] rdata_d;
   logic [7:0] flags_byte, mask_byte, pll_byte;

   assign flags_byte = {flags_q[fast_timer_pkg::CH_D], flags_q[fast_timer_pkg::CH_A],
                        flags_q[fast_timer_pkg::CH_B], 2'b00, flags_q[fast_timer_pkg::CH_OVF], 2'b00};
   assign mask_byte  = {mask_q[fast_timer_pkg::CH_D], mask_q[fast_timer_pkg::CH_A],
                        mask_q[fast_timer_pkg::CH_B], 2'b00, mask_q[fast_timer_pkg::CH_OVF], 2'b00};
   assign pll_byte   = {7'h00, pll_lock_flag_o};

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      unique case (addr)
         fast_timer_pkg::ADDR_HIGH_TEMP:  rdata_d = {6'h00, temp_q};
         fast_timer_pkg::ADDR_PLL_STATUS: rdata_d = pll_byte;
         fast_timer_pkg::ADDR_COUNT_LOW:  rdata_d = count_q[7:0];
         fast_timer_pkg::ADDR_CMP_A:      rdata_d = cmp_a_q[7:0];
         fast_timer_pkg::ADDR_CMP_B:      rdata_d = cmp_b_q[7:0];
         fast_timer_pkg::ADDR_CMP_D:      rdata_d = cmp_d_q[7:0];
         fast_timer_pkg::ADDR_TOP:        rdata_d = top_q[7:0];
         fast_timer_pkg::ADDR_IRQ_FLAGS:  rdata_d = flags_byte;
         fast_timer_pkg::ADDR_IRQ_MASK:   rdata_d = mask_byte;
         default:                         rdata_d = 8'h00;
      endcase
   end

   // All outputs are registered
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         io_rdata_o  <= 8'h00;
         count_o     <= fast_timer_pkg::COUNT_RST;
         cmp_match_o <= 4'h0;
         irq_o       <= 4'h0;
      end
      else
      begin
         io_rdata_o  <= rd ? rdata_d : 8'h00;
         count_o     <= count_q;
         cmp_match_o <= {top_evt, evt[fast_timer_pkg::CH_D:fast_timer_pkg::CH_B]};
         irq_o       <= flags_q & mask_q & {4{global_ie_i}};
      end
   end

endmodule // fast_timer_count_compare_regs

`default_nettype wire

// >>> verification/cpu_bus_model.sv
// Processor core model issuing byte reads and writes on the timer I/O bus
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model
(
   // Clock and read data in, request out
   input  wire logic                    clk_i,
   input  wire logic [7:0]              rdata_i,
   output var  fast_timer_pkg::io_req_t req_o
);
   initial req_o = '0;
   // Strobe held across exactly one rising edge, then released
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_i) req_o = '{1'b1, 1'b0, a, d};
      @(negedge clk_i) req_o = '0;
   endtask
   // Registered read data is taken one cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge clk_i) req_o = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_i) req_o = '0;
      d = rdata_i;
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// >>> verification/fast_timer_monitor.sv
// Concurrent checks on the ports of the fast timer count/compare block
`timescale 1ns/100ps
`default_nettype none
module fast_timer_monitor
(
   input wire logic clk_i, rstn_i, count_tick_i, global_ie_i, pll_enable_i, pll_locked_i,
   input wire fast_timer_pkg::io_req_t io_req_i,
   input wire fast_timer_pkg::timer_mode_t mode_i,
   input wire logic [3:0] irq_ack_i, cmp_match_o, irq_o,
   input wire logic [7:0] io_rdata_o,
   input wire logic pll_lock_flag_o, pll_settled_o,
   input wire logic [9:0] count_o
);
   // ==========================================================
   // Decode helpers
   wire logic rd_temp = io_req_i.rd && io_req_i.addr == fast_timer_pkg::ADDR_HIGH_TEMP;
   wire logic rd_mask = io_req_i.rd && io_req_i.addr == fast_timer_pkg::ADDR_IRQ_MASK;
   wire logic wr_cnt  = io_req_i.wr && io_req_i.addr == fast_timer_pkg::ADDR_COUNT_LOW;
   wire logic dual    = mode_i.pwm && mode_i.dual_slope;
   logic [7:0] wd_q;   // Last counter byte written
   logic [2:0] age_q;  // Cycles since that write, saturating
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) {wd_q, age_q} <= {8'h00, 3'h7};
      else if (wr_cnt) {wd_q, age_q} <= {io_req_i.wdata, 3'h0};
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================================
   // Properties
   property p_lock; pll_lock_flag_o |-> $past(pll_locked_i,2) || $past(pll_locked_i,3) || $past(pll_locked_i,4); endproperty
   a_lock: assert property (p_lock) else $error("lock flag without lock");
   property p_temp_rsv; $past(rd_temp) |-> io_rdata_o[7:2] == 6'h00; endproperty
   a_temp_rsv: assert property (p_temp_rsv) else $error("temp upper bits set");
   property p_mask_rsv; $past(rd_mask) |-> io_rdata_o[4:3] == 2'h0 && io_rdata_o[1:0] == 2'h0; endproperty
   a_mask_rsv: assert property (p_mask_rsv) else $error("mask unused bits set");
   property p_irq_gie; (|irq_o) |-> $past(global_ie_i); endproperty
   a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
   property p_wr_async; wr_cnt && mode_i.async_clk |-> ##[2:3] count_o[7:0] == wd_q; endproperty
   a_wr_async: assert property (p_wr_async) else $error("async write late");
   property p_wr_sync; wr_cnt && !mode_i.async_clk |-> ##[3:4] count_o[7:0] == wd_q; endproperty
   a_wr_sync: assert property (p_wr_sync) else $error("sync write late");
   property p_step; $changed(count_o) && !dual && age_q == 3'h7 |-> count_o == $past(count_o) + 10'h1 || count_o == 10'h0; endproperty
   a_step: assert property (p_step) else $error("count step wrong");
   property p_top; cmp_match_o[3] && !dual |-> ##[0:3] count_o == 10'h000; endproperty
   a_top: assert property (p_top) else $error("top match did not clear");
   c_match_a: cover property (cmp_match_o[1]);
   c_ovf_irq: cover property ($rose(irq_o[3]));
   c_wr_async: cover property (wr_cnt && mode_i.async_clk);
endmodule // fast_timer_monitor
bind fast_timer_count_compare_regs fast_timer_monitor mon_u
(
   .clk_i, .rstn_i, .count_tick_i, .global_ie_i, .pll_enable_i, .pll_locked_i, .io_req_i, .mode_i,
   .irq_ack_i, .cmp_match_o, .irq_o, .io_rdata_o, .pll_lock_flag_o, .pll_settled_o, .count_o
);
`default_nettype wire

// >>> verification/tb_fast_timer_count_compare_regs.sv
// Self-checking bench for the fast timer count/compare registers
`timescale 1ns/100ps
`default_nettype none
module tb_fast_timer_count_compare_regs;
   logic clk_i = 1'b0, rstn_i = 1'b0, tick = 1'b0, gie = 1'b0, pll_en = 1'b0, locked = 1'b0;
   logic [3:0] ack = 4'h0, match, irq;
   logic [7:0] rdata, d;
   logic [9:0] count;
   logic       lock_flag, settled;
   logic [37:0] r;
   fast_timer_pkg::io_req_t     io_req;
   fast_timer_pkg::timer_mode_t mode_i = '0;
   int failures = 0;
   int cmp_count = 0;
   localparam logic [5:0] A_TEMP = fast_timer_pkg::ADDR_HIGH_TEMP;
   localparam logic [5:0] A_CNT = fast_timer_pkg::ADDR_COUNT_LOW;
   // Rows: address, high byte, low byte, expected low read, expected temp read
   logic [37:0] rows [7] = '{{fast_timer_pkg::ADDR_CMP_A, 32'h01303001},
      {fast_timer_pkg::ADDR_CMP_B, 32'h01a5a501}, {fast_timer_pkg::ADDR_CMP_D, 32'h030f0f03},
      {fast_timer_pkg::ADDR_TOP, 32'h00010300}, {fast_timer_pkg::ADDR_IRQ_MASK, 32'h00ffe400},
      {A_TEMP, 32'h00ff0303}, {6'h3f, 32'h00ff0000}};
   fast_timer_count_compare_regs dut_u
   (
      .clk_i, .rstn_i, .io_req_i(io_req), .io_rdata_o(rdata), .mode_i,
      .count_tick_i(tick), .global_ie_i(gie), .irq_ack_i(ack), .pll_enable_i(pll_en),
      .pll_locked_i(locked), .pll_lock_flag_o(lock_flag), .pll_settled_o(settled),
      .count_o(count), .cmp_match_o(match), .irq_o(irq)
   );
   cpu_bus_model cpu_u (.clk_i, .rdata_i(rdata), .req_o(io_req));
   initial forever #20 clk_i = ~clk_i;
   // ==========================================================
   // Compare, verdict and stimulus helpers
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Bounded wait on one interrupt line; running out ends the run
   task automatic wait_irq(input int b, input logic v);
      for (int n = 0; n < 40 && irq[b] !== v; n++) @(negedge clk_i);
      chk({9'h0, irq[b]}, {9'h0, v});
      if (irq[b] !== v) final_report();
   endtask
   task automatic pulse_tick(input int n);
      @(negedge clk_i) tick = 1'b1;
      repeat (n) @(negedge clk_i);
      tick = 1'b0;
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (20) @(negedge clk_i);
      rstn_i = 1'b1;
      pll_en = 1'b1;
      repeat (4) @(negedge clk_i);
      chk({9'h0, settled}, 10'h000);
      locked = 1'b1;
      repeat (6) @(negedge clk_i);
      chk({9'h0, lock_flag}, 10'h001);
      locked = 1'b0;
      repeat (6) @(negedge clk_i);
      chk({9'h0, lock_flag}, 10'h000);
      foreach (rows[i])
      begin
         r = rows[i];
         cpu_u.wr(A_TEMP, r[31:24]);
         cpu_u.wr(r[37:32], r[23:16]);
         cpu_u.rd(r[37:32], d);
         chk({2'h0, d}, {2'h0, r[15:8]});
         cpu_u.rd(A_TEMP, d);
         chk({2'h0, d}, {2'h0, r[7:0]});
      end
      // Sync write, count into compare A, capture on low read
      cpu_u.wr(A_TEMP, 8'h01);
      cpu_u.wr(A_CNT, 8'h2e);
      repeat (6) @(negedge clk_i);
      chk(count, 10'h12e);
      gie = 1'b1;
      pulse_tick(2);
      repeat (2) @(negedge clk_i);
      chk(count, 10'h130);
      wait_irq(fast_timer_pkg::CH_A, 1'b1);
      cpu_u.wr(A_TEMP, 8'h00);
      cpu_u.rd(A_CNT, d);
      chk({2'h0, d}, 10'h030);
      cpu_u.rd(A_TEMP, d);
      chk({2'h0, d}, 10'h001);
      @(negedge clk_i) ack = 4'h2;
      @(negedge clk_i) ack = 4'h0;
      wait_irq(fast_timer_pkg::CH_A, 1'b0);
      cpu_u.wr(A_CNT, 8'h30);
      repeat (8) @(negedge clk_i);
      chk({9'h0, irq[fast_timer_pkg::CH_A]}, 10'h000);
      // Lock confirmed before fast clock, then wrap at minimum top
      locked = 1'b1;
      repeat (6) @(negedge clk_i);
      cpu_u.rd(fast_timer_pkg::ADDR_PLL_STATUS, d);
      chk({9'h0, d[0]}, 10'h001);
      mode_i.async_clk = 1'b1;
      cpu_u.wr(A_TEMP, 8'h00);
      cpu_u.wr(fast_timer_pkg::ADDR_TOP, 8'h00);
      cpu_u.wr(A_CNT, 8'h00);
      repeat (8) @(negedge clk_i);
      chk(count, 10'h000);
      pulse_tick(4);
      wait_irq(fast_timer_pkg::CH_OVF, 1'b1);
      chk(count, 10'h000);
      cpu_u.wr(fast_timer_pkg::ADDR_IRQ_FLAGS, 8'h04);
      wait_irq(fast_timer_pkg::CH_OVF, 1'b0);
      for (int n = 0; n < 2600 && settled !== 1'b1; n++) @(negedge clk_i);
      chk({9'h0, settled}, 10'h001);
      final_report();
   end
endmodule // tb_fast_timer_count_compare_regs
`default_nettype wire
